// file: logic/cpuxb_pkg.sv
/*
 * Shared definitions for the transfer and bit-operation execution unit:
 * operation codes, command layout, register offsets, flag positions.
 * Assumes a 32-bit APB master and byte addresses on paddr[11:0].
 */
package cpuxb_pkg;

    typedef enum logic [5:0] {
        OP_NOP, OP_BR_IRQ_EN, OP_BR_IRQ_DIS,
        OP_LD_PLAIN, OP_LD_POSTINC, OP_LD_PREDEC, OP_LD_DISP, OP_LD_DIRECT,
        OP_ST_PLAIN, OP_ST_POSTINC, OP_ST_PREDEC, OP_ST_DISP, OP_ST_DIRECT,
        OP_PM_LOAD_R0, OP_PM_LOAD, OP_PM_LOAD_INC,
        OP_PUSH, OP_POP, OP_IO_SET, OP_IO_CLR,
        OP_ROT_LEFT, OP_ROT_RIGHT, OP_BIT_TO_T, OP_T_TO_BIT,
        OP_FLAG_SET, OP_FLAG_CLR, OP_SLEEP, OP_BREAK, OP_LAST
    } cpuxb_op_t;

    typedef struct packed {
        logic [1:0] ptr;
        logic [2:0] bitn;
        logic [4:0] rsel;
        cpuxb_op_t op;
    } cpuxb_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SLEEP, ST_HALT} cpuxb_state_t;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_BIT_LSB = 16;
    localparam int CMD_PTR_LSB = 20;

    // Register byte offsets
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_ARG = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam logic [11:0] OFS_FLAGS = 12'h00C;
    localparam logic [11:0] OFS_PC = 12'h010;
    localparam logic [11:0] OFS_SP = 12'h014;
    localparam logic [3:0] REGION_CTRL = 4'h0;
    localparam logic [3:0] REGION_GPR = 4'h1;
    localparam logic [3:0] REGION_IO = 4'h2;
    localparam logic [2:0] REGION_DMEM = 3'h2;
    localparam logic [2:0] REGION_PMEM = 3'h4;

    // Status register bit positions
    localparam int FL_C = 0;
    localparam int FL_Z = 1;
    localparam int FL_N = 2;
    localparam int FL_V = 3;
    localparam int FL_T = 6;
    localparam int FL_I = 7;

    // Status word bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_SLEEP = 1;
    localparam int STAT_HALT = 2;
    localparam int STAT_FLAGS_LSB = 8;

    localparam int PTR_BASE = 26;
    localparam int MEM_AW = 8;
    localparam int IO_AW = 5;
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] TWO16 = 16'h0002;

endpackage : cpuxb_pkg

// file: logic/cpuxb_core.sv
/*
 * Execution unit for pointer loads and stores, program-memory loads,
 * stack, I/O bit set/clear, rotates, transfer-flag and flag operations,
 * interrupt-flag branches, sleep and break, driven over APB.
 * Assumes one clock, an APB master that holds each request until pready.
 */
// Functional notes
// - Branch adds offset plus one when interrupts enabled; one or two cycles.
// - Branch adds offset plus one when interrupts disabled; one or two cycles.
// - Post-increment load reads at pointer then bumps pointer; two cycles.
// - Pre-decrement load drops pointer first then reads; two cycles.
// - Displacement load reads the ptr-selected pointer plus offset; two cycles.
// - Direct load reads sixteen-bit address into register; two cycles.
// - Post-increment store writes at pointer then bumps it; two cycles.
// - Pre-decrement store drops pointer then writes there; two cycles.
// - Displacement store writes at pointer plus offset, pointer kept.
// - Direct store writes to instruction address; two cycles, no flags.
// - Program-memory load via third pointer, optional increment; three cycles.
// - Push writes register to stack in two cycles, flags kept.
// - Pop moves stack top into register in two cycles, flags kept.
// - I/O bit set forces one bit high, two cycles, flags kept.
// - I/O bit clear forces one bit low, two cycles, flags kept.
// - Rotate left through carry, updates Z C N V, one cycle.
// - Rotate right through carry, updates Z C N V, one cycle.
// - Register bit copied into transfer flag, one cycle.
// - Transfer flag copied into register bit, one cycle, flags kept.
// - Each flag set or clear touches only its own bit, one cycle.
// - Sleep takes one cycle, keeps flags, then enters low power.
// - Break only halts for debug; one cycle, flags kept.
`timescale 1ns/1ps
module cpuxb_core
    import cpuxb_pkg::*;
(
    input wire logic pclk, // 250 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic sleep_req, // low-power request to sleep control
    output logic debug_halt // stopped on break
);

    // Not reset: software loads registers and memories before use
    logic [7:0] gpr [32];
    logic [7:0] dmem [2**MEM_AW];
    logic [7:0] pmem [2**MEM_AW];
    logic [7:0] io [2**IO_AW];

    cpuxb_state_t state_q;
    cpuxb_cmd_t cmd_q;
    logic [15:0] arg_q, pc_q, sp_q;
    logic [7:0] flags_q;
    logic [1:0] cnt_q;
    logic taken_q;
    logic busy_q;

    // Taken branches cost one cycle more than untaken ones
    function automatic logic [1:0] cycles_of(cpuxb_op_t op, logic taken);
        unique case (op)
            OP_BR_IRQ_EN, OP_BR_IRQ_DIS: cycles_of = taken ? CYC_TWO : CYC_ONE;
            OP_LD_PLAIN, OP_LD_POSTINC, OP_LD_PREDEC, OP_LD_DISP,
            OP_LD_DIRECT, OP_ST_PLAIN, OP_ST_POSTINC, OP_ST_PREDEC,
            OP_ST_DISP, OP_ST_DIRECT, OP_PUSH, OP_POP,
            OP_IO_SET, OP_IO_CLR: cycles_of = CYC_TWO;
            OP_PM_LOAD_R0, OP_PM_LOAD, OP_PM_LOAD_INC: cycles_of = CYC_THREE;
            default: cycles_of = CYC_ONE;
        endcase
    endfunction : cycles_of

    // Ops that write the pointer pair back
    function automatic logic is_pair_op(cpuxb_op_t op);
        is_pair_op = op inside {OP_LD_POSTINC, OP_LD_PREDEC, OP_ST_POSTINC,
            OP_ST_PREDEC, OP_PM_LOAD_INC};
    endfunction : is_pair_op

    function automatic logic is_pm_op(cpuxb_op_t op);
        is_pm_op = op inside {OP_PM_LOAD_R0, OP_PM_LOAD, OP_PM_LOAD_INC};
    endfunction : is_pm_op

    function automatic logic br_taken(cpuxb_op_t op, logic iflag);
        br_taken = op == OP_BR_IRQ_EN ? iflag : !iflag;
    endfunction : br_taken

    // APB: one wait state so read data and error come from flops
    logic ap_setup, ap_done;
    logic [11:0] a;
    assign ap_setup = psel & penable & ~pready;
    assign ap_done = psel & penable & pready & ~pslverr;
    assign a = paddr;

    logic in_gpr, in_io, in_dmem, in_pmem, is_ctrl, cmd_wr;
    logic [4:0] w_idx;
    logic [MEM_AW-1:0] m_idx;
    assign in_gpr = a[11:8] == REGION_GPR && !a[7];
    assign in_io = a[11:8] == REGION_IO && !a[7];
    assign in_dmem = a[11:10] == REGION_DMEM[2:1];
    assign in_pmem = a[11:10] == REGION_PMEM[2:1];
    assign is_ctrl = a[11:8] == REGION_CTRL;
    assign w_idx = a[6:2];
    assign m_idx = a[MEM_AW+1:2];
    assign cmd_wr = ap_done && pwrite && a == OFS_CMD;

    // Illegal opcodes and misaligned addresses are refused
    logic mapped, bad_op, refuse;
    always_comb begin
        mapped = in_gpr | in_io | in_dmem | in_pmem;
        if (is_ctrl) begin
            mapped = a inside {OFS_CMD, OFS_ARG, OFS_STAT, OFS_FLAGS,
                OFS_PC, OFS_SP};
        end
        mapped = mapped && a[1:0] == 2'h0;
        bad_op = pwdata[CMD_OP_LSB +: 6] >= 6'(OP_LAST);
        refuse = !mapped;
        if (pwrite && a == OFS_CMD) begin
            refuse = refuse | bad_op | (state_q == ST_EXEC);
        end else if (pwrite && a != OFS_ARG) begin
            // Architectural state is frozen while an operation runs
            refuse = refuse | (state_q == ST_EXEC);
        end
    end

    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        if (in_gpr) begin
            rd_d[7:0] = gpr[w_idx];
        end else if (in_io) begin
            rd_d[7:0] = io[w_idx];
        end else if (in_dmem) begin
            rd_d[7:0] = dmem[m_idx];
        end else if (in_pmem) begin
            rd_d[7:0] = pmem[m_idx];
        end else begin
            unique case (a)
                OFS_CMD: begin
                    // Read back in the layout software wrote
                    rd_d[CMD_OP_LSB +: 6] = cmd_q.op;
                    rd_d[CMD_REG_LSB +: 5] = cmd_q.rsel;
                    rd_d[CMD_BIT_LSB +: 3] = cmd_q.bitn;
                    rd_d[CMD_PTR_LSB +: 2] = cmd_q.ptr;
                end
                OFS_ARG: rd_d[15:0] = arg_q;
                OFS_STAT: begin
                    rd_d[STAT_BUSY] = busy_q;
                    rd_d[STAT_SLEEP] = sleep_req;
                    rd_d[STAT_HALT] = debug_halt;
                    rd_d[STAT_FLAGS_LSB +: 8] = flags_q;
                end
                OFS_FLAGS: rd_d[7:0] = flags_q;
                OFS_PC: rd_d[15:0] = pc_q;
                OFS_SP: rd_d[15:0] = sp_q;
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= ap_setup;
            pslverr <= ap_setup & refuse;
            if (ap_setup) begin
                // Writes and refused accesses read back as zero
                prdata <= (refuse || pwrite) ? 32'h0000_0000 : rd_d;
            end
        end
    end

    // Operand and effect computation for the running command
    logic commit;
    logic [4:0] p_lo, p_hi;
    logic [15:0] ptr_v, ptr_new, eff;
    logic [7:0] src, ld_val, rot_val, io_new;
    logic rot_c;
    cpuxb_op_t op_in;
    logic taken_in;
    // Effects land on the last cycle of the count
    assign commit = state_q == ST_EXEC && cnt_q == CYC_ONE;
    assign op_in = cpuxb_op_t'(pwdata[CMD_OP_LSB +: 6]);
    // Outcome frozen at issue from the interrupt flag of that moment
    assign taken_in = br_taken(op_in, flags_q[FL_I]);

    always_comb begin
        p_lo = 5'(PTR_BASE) + {2'h0, cmd_q.ptr, 1'b0};
        if (is_pm_op(cmd_q.op)) begin
            // Program memory is reached through the third pair only
            p_lo = 5'(PTR_BASE) + {2'h0, PTR_Z, 1'b0};
        end
        p_hi = p_lo + 5'h01;
        // Sixteen-bit sums wrap, so the pointer rolls over cleanly
        ptr_v = {gpr[p_hi], gpr[p_lo]};
        ptr_new = ptr_v + ONE16;
        eff = ptr_v;
        src = gpr[cmd_q.rsel];
        unique case (cmd_q.op)
            OP_LD_PREDEC, OP_ST_PREDEC: begin
                ptr_new = ptr_v - ONE16;
                eff = ptr_new;
            end
            OP_LD_DISP, OP_ST_DISP: eff = ptr_v + {10'h000, arg_q[5:0]};
            OP_LD_DIRECT, OP_ST_DIRECT: eff = arg_q;
            OP_PUSH: eff = sp_q;
            OP_POP: eff = sp_q + ONE16;
            default: eff = ptr_v;
        endcase
        ld_val = dmem[eff[MEM_AW-1:0]];
        if (is_pm_op(cmd_q.op)) begin
            ld_val = pmem[eff[MEM_AW-1:0]];
        end
        if (cmd_q.op == OP_ROT_LEFT) begin
            rot_val = {src[6:0], flags_q[FL_C]};
            rot_c = src[7];
        end else begin
            rot_val = {flags_q[FL_C], src[7:1]};
            rot_c = src[0];
        end
        io_new = io[arg_q[IO_AW-1:0]];
        // Write-one-to-clear flags read as set are written back as ones
        io_new[cmd_q.bitn] = cmd_q.op == OP_IO_SET;
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= CYC_ONE;
            taken_q <= 1'b0;
            busy_q <= 1'b0;
            sleep_req <= 1'b0;
            debug_halt <= 1'b0;
            cmd_q <= '0;
        end else if (cmd_wr) begin
            // Issue: latch fields, freeze the outcome, load the count
            cmd_q <= {pwdata[CMD_PTR_LSB +: 2], pwdata[CMD_BIT_LSB +: 3],
                pwdata[CMD_REG_LSB +: 5], op_in};
            taken_q <= taken_in;
            cnt_q <= cycles_of(op_in, taken_in);
            state_q <= ST_EXEC;
            busy_q <= 1'b1;
            sleep_req <= 1'b0;
            debug_halt <= 1'b0;
        end else if (state_q == ST_EXEC) begin
            cnt_q <= cnt_q - CYC_ONE;
            if (commit) begin
                busy_q <= 1'b0;
                unique case (cmd_q.op)
                    OP_SLEEP: begin
                        state_q <= ST_SLEEP;
                        sleep_req <= 1'b1;
                    end
                    OP_BREAK: begin
                        state_q <= ST_HALT;
                        debug_halt <= 1'b1;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Program counter; branch offset is a signed 7-bit word count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= 16'h0000;
        end else if (ap_done && pwrite && a == OFS_PC) begin
            pc_q <= pwdata[15:0];
        end else if (commit) begin
            if (cmd_q.op inside {OP_BR_IRQ_EN, OP_BR_IRQ_DIS} && taken_q) begin
                pc_q <= pc_q + {{9{arg_q[6]}}, arg_q[6:0]} + ONE16;
            end else if (cmd_q.op inside {OP_LD_DIRECT, OP_ST_DIRECT}) begin
                pc_q <= pc_q + TWO16;
            end else if (cmd_q.op != OP_BREAK) begin
                pc_q <= pc_q + ONE16;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arg_q <= 16'h0000;
        end else if (ap_done && pwrite && a == OFS_ARG) begin
            arg_q <= pwdata[15:0];
        end
    end

    // Stack pointer: post-decrement push, pre-increment pop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= SP_RESET;
        end else if (ap_done && pwrite && a == OFS_SP) begin
            sp_q <= pwdata[15:0];
        end else if (commit && cmd_q.op == OP_PUSH) begin
            sp_q <= sp_q - ONE16;
        end else if (commit && cmd_q.op == OP_POP) begin
            sp_q <= sp_q + ONE16;
        end
    end

    // Status flags; transfers, stack and I/O ops leave them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 8'h00;
        end else if (ap_done && pwrite && a == OFS_FLAGS) begin
            flags_q <= pwdata[7:0];
        end else if (commit) begin
            unique case (cmd_q.op)
                OP_ROT_LEFT, OP_ROT_RIGHT: begin
                    flags_q[FL_C] <= rot_c;
                    flags_q[FL_Z] <= rot_val == 8'h00;
                    flags_q[FL_N] <= rot_val[7];
                    flags_q[FL_V] <= rot_val[7] ^ rot_c;
                end
                OP_BIT_TO_T: flags_q[FL_T] <= src[cmd_q.bitn];
                OP_FLAG_SET: flags_q[cmd_q.bitn] <= 1'b1;
                OP_FLAG_CLR: flags_q[cmd_q.bitn] <= 1'b0;
                default: flags_q <= flags_q;
            endcase
        end
    end

    // Register file: data result first, pointer update wins on overlap
    always_ff @(posedge pclk) begin
        if (ap_done && pwrite && in_gpr) begin
            gpr[w_idx] <= pwdata[7:0];
        end else if (commit) begin
            unique case (cmd_q.op)
                OP_LD_PLAIN, OP_LD_POSTINC, OP_LD_PREDEC, OP_LD_DISP,
                OP_LD_DIRECT, OP_POP, OP_PM_LOAD, OP_PM_LOAD_INC:
                    gpr[cmd_q.rsel] <= ld_val;
                OP_PM_LOAD_R0: gpr[0] <= ld_val;
                OP_ROT_LEFT, OP_ROT_RIGHT: gpr[cmd_q.rsel] <= rot_val;
                OP_T_TO_BIT: gpr[cmd_q.rsel][cmd_q.bitn] <= flags_q[FL_T];
                default: ;
            endcase
            if (is_pair_op(cmd_q.op)) begin
                gpr[p_lo] <= ptr_new[7:0];
                gpr[p_hi] <= ptr_new[15:8];
            end
        end
    end

    // Data memory, program memory image and I/O space
    always_ff @(posedge pclk) begin
        if (ap_done && pwrite && in_dmem) begin
            dmem[m_idx] <= pwdata[7:0];
        end else if (commit && cmd_q.op inside {OP_ST_PLAIN, OP_ST_POSTINC,
                OP_ST_PREDEC, OP_ST_DISP, OP_ST_DIRECT, OP_PUSH}) begin
            dmem[eff[MEM_AW-1:0]] <= src;
        end
    end

    always_ff @(posedge pclk) begin
        if (ap_done && pwrite && in_pmem) begin
            pmem[m_idx] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (ap_done && pwrite && in_io) begin
            io[w_idx] <= pwdata[7:0];
        end else if (commit && cmd_q.op inside {OP_IO_SET, OP_IO_CLR}) begin
            // Whole register rewritten, so other bits keep their read value
            io[arg_q[IO_AW-1:0]] <= io_new;
        end
    end

endmodule : cpuxb_core

// file: dv/cpuxb_assertions.sv
/* Checker for the execution unit's ports: sleep and halt outputs against
   accepted command writes, status bits and the APB answer shape.
   Assumes an APB master that holds each request until pready. */
`timescale 1ns/1ps
module cpuxb_assertions
    import cpuxb_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic sleep_req, // sleep request
    input wire logic debug_halt // halted
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done_w;
    logic cmd_ok;
    logic stat_rd;
    assign done_w = psel && penable && pready && !pslverr;
    assign cmd_ok = done_w && pwrite && paddr == OFS_CMD;
    assign stat_rd = done_w && !pwrite && paddr == OFS_STAT;
    AST_SLEEP_RISE: assert property (
        cmd_ok && pwdata[5:0] == OP_SLEEP |-> ##[1:3] sleep_req)
        else $error("sleep request not raised");
    AST_HALT_RISE: assert property (
        cmd_ok && pwdata[5:0] == OP_BREAK |-> ##[1:3] debug_halt)
        else $error("halt not raised");
    AST_SLEEP_HOLD: assert property (
        sleep_req && !cmd_ok |=> sleep_req)
        else $error("sleep request dropped early");
    AST_HALT_HOLD: assert property (
        debug_halt && !cmd_ok |=> debug_halt)
        else $error("halt dropped early");
    AST_CMD_RESUMES: assert property (
        cmd_ok |-> ##[1:2] (!sleep_req && !debug_halt))
        else $error("command did not resume");
    AST_STAT_SLEEP: assert property (
        stat_rd && $stable(sleep_req) |-> prdata[STAT_SLEEP] == sleep_req)
        else $error("status sleep bit wrong");
    AST_STAT_HALT: assert property (
        stat_rd && $stable(debug_halt) |-> prdata[STAT_HALT] == debug_halt)
        else $error("status halt bit wrong");
    AST_SLEEP_IDLE: assert property (
        stat_rd && prdata[STAT_SLEEP] |-> !prdata[STAT_BUSY])
        else $error("busy while asleep");
    AST_ONE_WAIT: assert property (
        psel && $rose(penable) |=> pready ##1 !pready)
        else $error("answer not in second access cycle");
endmodule : cpuxb_assertions

bind cpuxb_core cpuxb_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .debug_halt(debug_halt));

// file: dv/cpuxb_apb_host.sv
/* APB master standing in for software, one transfer at a time.
   Assumes callers enter the task at or after a rising edge. */
`timescale 1ns/1ps
module cpuxb_apb_host (
    input wire logic pclk, // clock
    output logic psel, // select
    output logic penable, // enable
    output logic pwrite, // direction
    output logic [11:0] paddr, // address
    output logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // error
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Leading edge wait keeps psel from two updates in one step
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cpuxb_apb_host

// file: dv/cpuxb_core_bench.sv
/* Self-checking bench: table of commands with the register or memory
   word each should leave, then flags, branches, wrap, sleep, reset.
   Assumes the APB host model and the bound checker. */
`timescale 1ns/1ps
module cpuxb_core_bench;
    import cpuxb_pkg::*;
    typedef struct {
        cpuxb_op_t op;
        int rs;
        int b;
        int p;
        int arg;
        logic [11:0] ca;
        logic [31:0] ev;
    } cpuxb_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sleep_req, debug_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    logic [7:0] m;
    int errors = 0;
    int n_compared = 0;
    cpuxb_row_t rows [28];
    cpuxb_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .debug_halt(debug_halt));
    cpuxb_apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    function automatic logic [11:0] ga(input int n);
        return 12'h100 + 12'(n * 4);
    endfunction : ga
    function automatic logic [11:0] da(input int n);
        return 12'h400 + 12'(n * 4);
    endfunction : da
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        u_host.xfer(1'b1, a, d, x, y);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic y;
        u_host.xfer(1'b0, a, 32'h0, d, y);
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input cpuxb_op_t op, input int r, input int b,
        input int p, input int arg);
        logic [31:0] s;
        logic slow;
        slow = op inside {OP_PM_LOAD_R0, OP_PM_LOAD, OP_PM_LOAD_INC};
        wr(OFS_ARG, {16'h0, 16'(arg)});
        wr(OFS_CMD, {10'h0, 2'(p), 1'b0, 3'(b), 3'h0, 5'(r), 2'h0, op});
        // First poll lands three edges after issue: only 3-cycle ops busy
        rd(OFS_STAT, s);
        chk({31'h0, s[0]}, {31'h0, slow});
        for (int k = 0; k < 20 && s[0] !== 1'b0; k++) rd(OFS_STAT, s);
        chk({31'h0, s[0]}, 32'h0);
    endtask : run
    task automatic wrap_up;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
    initial begin
        rows = '{
            '{OP_LD_POSTINC, 1, 0, 0, 0, ga(1), 32'hA1},
            '{OP_NOP, 0, 0, 0, 0, ga(26), 32'h11},
            '{OP_LD_PREDEC, 2, 0, 0, 0, ga(2), 32'hA1},
            '{OP_LD_DISP, 3, 0, 1, 5, ga(3), 32'hB2},
            '{OP_NOP, 0, 0, 0, 0, ga(28), 32'h20},
            '{OP_LD_DIRECT, 4, 0, 0, 'h40, ga(4), 32'hC3},
            '{OP_ST_POSTINC, 5, 0, 0, 0, da(16), 32'h3C},
            '{OP_NOP, 0, 0, 0, 0, ga(26), 32'h11},
            '{OP_ST_PREDEC, 5, 0, 1, 0, da(31), 32'h3C},
            '{OP_ST_DISP, 5, 0, 2, 2, da(50), 32'h3C},
            '{OP_ST_DIRECT, 5, 0, 0, 'h50, da(80), 32'h3C},
            '{OP_PM_LOAD_R0, 0, 0, 2, 0, ga(0), 32'hE5},
            '{OP_PM_LOAD, 6, 0, 2, 0, ga(6), 32'hE5},
            '{OP_PM_LOAD_INC, 7, 0, 2, 0, ga(30), 32'h31},
            '{OP_PUSH, 5, 0, 0, 0, da(255), 32'h3C},
            '{OP_NOP, 0, 0, 0, 0, OFS_SP, 32'hFE},
            '{OP_POP, 9, 0, 0, 0, ga(9), 32'h3C},
            '{OP_NOP, 0, 0, 0, 0, OFS_SP, 32'hFF},
            '{OP_IO_SET, 0, 2, 0, 3, 12'h20C, 32'hF4},
            '{OP_IO_CLR, 0, 4, 0, 3, 12'h20C, 32'hE4},
            '{OP_NOP, 0, 0, 0, 0, OFS_FLAGS, 32'h00},
            '{OP_ROT_LEFT, 8, 0, 0, 0, ga(8), 32'h02},
            '{OP_NOP, 0, 0, 0, 0, OFS_FLAGS, 32'h09},
            '{OP_ROT_RIGHT, 8, 0, 0, 0, ga(8), 32'h81},
            '{OP_NOP, 0, 0, 0, 0, OFS_FLAGS, 32'h0C},
            '{OP_BIT_TO_T, 8, 7, 0, 0, OFS_FLAGS, 32'h4C},
            '{OP_T_TO_BIT, 10, 3, 0, 0, ga(10), 32'h08},
            '{OP_NOP, 0, 0, 0, 0, OFS_FLAGS, 32'h4C}};
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wr(ga(26), 32'h10);
        wr(ga(27), 32'h00);
        wr(ga(28), 32'h20);
        wr(ga(29), 32'h00);
        wr(ga(30), 32'h30);
        wr(ga(31), 32'h00);
        wr(ga(5), 32'h3C);
        wr(ga(8), 32'h81);
        wr(ga(10), 32'h00);
        wr(da(16), 32'hA1);
        wr(da(37), 32'hB2);
        wr(da(64), 32'hC3);
        wr(12'h8C0, 32'hE5);
        wr(12'h20C, 32'hF0);
        wr(OFS_FLAGS, 32'h0);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].rs, rows[i].b, rows[i].p, rows[i].arg);
            rd(rows[i].ca, q);
            chk(q, rows[i].ev);
        end
        wr(OFS_FLAGS, 32'h0);
        for (int i = 0; i < 16; i++) begin
            run(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 0, i % 8, 0, 0);
            m = 8'hFF << ((i % 8) + 1);
            rd(OFS_FLAGS, q);
            chk(q, {24'h0, i < 8 ? ~m : m});
        end
        for (int s = 0; s < 4; s++) begin
            wr(OFS_PC, 32'h100);
            wr(OFS_FLAGS, {24'h0, s[1], 7'h0});
            run(s[0] ? OP_BR_IRQ_DIS : OP_BR_IRQ_EN, 0, 0, 0,
                s[1] ? 'h7C : 'h05);
            rd(OFS_PC, q);
            if (s[1] != s[0])
                chk(q, s[1] ? 32'hFD : 32'h106);
            else
                chk(q, 32'h101);
        end
        wr(ga(26), 32'hFF);
        wr(ga(27), 32'hFF);
        run(OP_LD_POSTINC, 1, 0, 0, 0);
        rd(ga(27), q);
        chk(q, 32'h00);
        run(OP_LD_PREDEC, 1, 0, 0, 0);
        rd(ga(27), q);
        chk(q, 32'hFF);
        u_host.xfer(1'b1, OFS_CMD, {26'h0, OP_LAST}, q, e);
        chk({31'h0, e}, 32'h1);
        wr(OFS_FLAGS, 32'h5A);
        run(OP_SLEEP, 0, 0, 0, 0);
        chk({31'h0, sleep_req}, 32'h1);
        rd(OFS_STAT, q);
        chk({24'h0, q[7:0]}, 32'h02);
        run(OP_BREAK, 0, 0, 0, 0);
        chk({30'h0, sleep_req, debug_halt}, 32'h1);
        rd(OFS_FLAGS, q);
        chk(q, 32'h5A);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({30'h0, pready, debug_halt}, 32'h0);
        presetn <= 1'b1;
        rd(OFS_SP, q);
        chk(q, 32'hFF);
        rd(OFS_PC, q);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule : cpuxb_core_bench
